// ### rtl/sic_top.sv
// SPI/I2S data register, checksum unit and audio configuration with APB access
//
// Overview of operation
// - Data writes fill transmit, reads give receive
// - Byte frames use low byte only
// - Writable checksum polynomial, resets to 0x0007
// - Receive checksum, 8 or 16 bits, read-only
// - Transmit checksum, width follows frame length
// - Enabling checksum clears both checksum results
// - Channel width bit: 16 or 32
// - Sample width 16/24/32, code 11 refused
// - Idle clock level bit
// - PCM sync length select, PCM only
// - Two-bit audio role select
// - Audio settings locked while audio enabled
// - Protocol select locked while enabled
// - Busy flag kept by hardware
// - Checksum mismatch raises error flag
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module sic_top
  import sic_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spi_sck,
  input  wire logic        spi_sel_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso_o,
  output logic             spi_miso_oe,
  output logic             audio_active,
  output logic             audio_chan32,
  output logic      [1:0]  audio_sample_width,
  output logic             idle_clock_level,
  output logic      [1:0]  audio_standard_select,
  output logic             pcm_sync_length_select,
  output logic      [1:0]  audio_role_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic sic_mapped(input logic [7:0] a);
    return a == SIC_CTRL_OFS || a == SIC_STAT_OFS || a == SIC_DATA_OFS ||
           a == SIC_POLY_OFS || a == SIC_RXCK_OFS || a == SIC_TXCK_OFS ||
           a == SIC_ACFG_OFS;
  endfunction : sic_mapped

  logic        acc;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_data;
  logic        wr_poly;
  logic        wr_acfg;
  logic        rd_data;

  assign acc     = psel & penable;
  assign wr_ctrl = acc & pwrite & (paddr == SIC_CTRL_OFS);
  assign wr_stat = acc & pwrite & (paddr == SIC_STAT_OFS);
  assign wr_data = acc & pwrite & (paddr == SIC_DATA_OFS);
  assign wr_poly = acc & pwrite & (paddr == SIC_POLY_OFS);
  assign wr_acfg = acc & pwrite & (paddr == SIC_ACFG_OFS);
  assign rd_data = acc & ~pwrite & (paddr == SIC_DATA_OFS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~sic_mapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic              spi_en_r;
  logic              frm16_r;
  logic              ck_en_r;
  logic              ck_next_r;
  logic [15:0]       poly_r;
  logic [15:0]       tx_buf_r;
  logic [15:0]       rx_buf_r;
  logic              txe_r;
  logic              rxne_r;
  logic              ckerr_r;
  logic [15:0]       rx_ck_r;
  logic [15:0]       tx_ck_r;
  logic              chw_r;
  sic_width_t        sw_r;
  logic              idle_clock_level_r;
  sic_std_t          std_r;
  logic              pfs_r;
  sic_role_t         role_r;
  logic              aen_r;
  logic              psel_bit_r;
  logic              busy;
  logic              ck_clr;
  logic              frame_done;
  logic              load_go;
  logic              ck_frame_r;
  logic [15:0]       rx_word;
  logic [15:0]       tx_word_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_en_r <= SIC_CTRL_RST[SIC_CTRL_SPI_EN];
      frm16_r  <= SIC_CTRL_RST[SIC_CTRL_FRM16];
      ck_en_r  <= SIC_CTRL_RST[SIC_CTRL_CK_EN];
    end else if (wr_ctrl) begin
      spi_en_r <= pwdata[SIC_CTRL_SPI_EN];
      frm16_r  <= pwdata[SIC_CTRL_FRM16];
      ck_en_r  <= pwdata[SIC_CTRL_CK_EN];
    end
  end

  // Checksum frame request: hardware takes it at the next frame load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_next_r <= SIC_CTRL_RST[SIC_CTRL_CK_NEXT];
    end else if (wr_ctrl && pwdata[SIC_CTRL_CK_NEXT]) begin
      ck_next_r <= 1'b1;
    end else if (load_go) begin
      ck_next_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poly_r <= SIC_POLY_RST;
    end else if (wr_poly) begin
      poly_r <= pwdata[15:0];
    end
  end

  // Transmit buffer and its empty flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_r <= SIC_DATA_RST;
      txe_r    <= 1'b1;
    end else begin
      if (load_go && !ck_next_r) begin
        txe_r <= 1'b1;
      end
      if (wr_data) begin
        tx_buf_r <= frm16_r ? pwdata[15:0] : {8'h00, pwdata[7:0]};
        txe_r    <= 1'b0;
      end
    end
  end

  // Receive buffer; a new frame wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_r <= SIC_DATA_RST;
      rxne_r   <= 1'b0;
    end else if (frame_done) begin
      rx_buf_r <= rx_word;
      rxne_r   <= 1'b1;
    end else if (rd_data) begin
      rxne_r   <= 1'b0;
    end
  end

  // Checksum error: set wins over a write of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ckerr_r <= 1'b0;
    end else if (frame_done && ck_frame_r && rx_word != rx_ck_r) begin
      ckerr_r <= 1'b1;
    end else if (wr_stat && !pwdata[SIC_STAT_CKERR]) begin
      ckerr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum results
  sic_crc_if rx_ck ();
  sic_crc_if tx_ck ();

  assign rx_ck.poly = poly_r;
  assign rx_ck.cur  = rx_ck_r;
  assign rx_ck.data = rx_word;
  assign rx_ck.wide = frm16_r;
  assign tx_ck.poly = poly_r;
  assign tx_ck.cur  = tx_ck_r;
  assign tx_ck.data = tx_word_r;
  assign tx_ck.wide = frm16_r;

  sic_crc u_rx_ck (
    .ck (rx_ck.engine)
  );

  sic_crc u_tx_ck (
    .ck (tx_ck.engine)
  );

  assign ck_clr = wr_ctrl & pwdata[SIC_CTRL_CK_EN] & ~ck_en_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ck_r <= SIC_CK_RST;
      tx_ck_r <= SIC_CK_RST;
    end else if (ck_clr) begin
      rx_ck_r <= SIC_CK_RST;
      tx_ck_r <= SIC_CK_RST;
    end else if (frame_done && ck_en_r && !ck_frame_r) begin
      rx_ck_r <= rx_ck.nxt;
      tx_ck_r <= tx_ck.nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Audio configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chw_r      <= 1'b0;
      sw_r       <= SIC_SW16;
      idle_clock_level_r     <= 1'b0;
      std_r      <= SIC_STD_I2S;
      pfs_r      <= 1'b0;
      role_r     <= SIC_ROLE_STX;
      aen_r      <= 1'b0;
      psel_bit_r <= 1'b0;
    end else if (wr_acfg) begin
      if (!aen_r) begin
        chw_r  <= pwdata[SIC_ACFG_CHW];
        idle_clock_level_r <= pwdata[SIC_ACFG_IDLE_CLOCK_LEVEL];
        std_r  <= sic_std_t'(pwdata[SIC_ACFG_STD +: 2]);
        pfs_r  <= pwdata[SIC_ACFG_PFS];
        role_r <= sic_role_t'(pwdata[SIC_ACFG_ROLE +: 2]);
        if (pwdata[SIC_ACFG_SW +: 2] != SIC_SWBAD) begin
          sw_r <= sic_width_t'(pwdata[SIC_ACFG_SW +: 2]);
        end
      end
      aen_r <= pwdata[SIC_ACFG_AEN];
      if (!aen_r && !spi_en_r) begin
        psel_bit_r <= pwdata[SIC_ACFG_PSEL];
      end
    end
  end

  // Audio settings reach the serial side only in audio protocol
  assign audio_active           = psel_bit_r & aen_r;
  assign audio_chan32           = psel_bit_r & (chw_r | (sw_r != SIC_SW16));
  assign audio_sample_width     = psel_bit_r ? sw_r : SIC_SW16;
  assign idle_clock_level       = psel_bit_r & idle_clock_level_r;
  assign audio_standard_select  = psel_bit_r ? std_r : SIC_STD_I2S;
  assign pcm_sync_length_select = psel_bit_r & (std_r == SIC_STD_PCM) & pfs_r;
  assign audio_role_select      = psel_bit_r ? role_r : SIC_ROLE_STX;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_s3_r;
  logic sel_s1_r;
  logic sel_s2_r;
  logic sel_s3_r;
  logic mosi_s1_r;
  logic mosi_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      sel_s1_r  <= 1'b1;
      sel_s2_r  <= 1'b1;
      sel_s3_r  <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end else begin
      sck_s1_r  <= spi_sck;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      sel_s1_r  <= spi_sel_n;
      sel_s2_r  <= sel_s1_r;
      sel_s3_r  <= sel_s2_r;
      mosi_s1_r <= spi_mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  logic spi_on;

  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign sck_fall = ~sck_s2_r & sck_s3_r;
  assign sel_fall = ~sel_s2_r & sel_s3_r;
  assign spi_on   = spi_en_r & ~psel_bit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave, idle-low clock, sample on rise, shift on fall
  sic_state_t  state_r;
  logic [3:0]  cnt_r;
  logic [15:0] rx_sh_r;
  logic [15:0] tx_sh_r;
  logic [3:0]  last_bit;

  assign last_bit   = frm16_r ? SIC_LAST16 : SIC_LAST8;
  assign frame_done = (state_r == SIC_ST_SHIFT) & ~sel_s2_r & sck_rise & (cnt_r == last_bit);
  assign load_go    = ((state_r == SIC_ST_IDLE) & spi_on & sel_fall) | frame_done;
  assign rx_word    = frm16_r ? {rx_sh_r[14:0], mosi_s2_r}
                              : {8'h00, rx_sh_r[6:0], mosi_s2_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SIC_ST_IDLE;
    end else begin
      unique case (state_r)
        SIC_ST_IDLE: begin
          if (spi_on && sel_fall) begin
            state_r <= SIC_ST_SHIFT;
          end
        end
        SIC_ST_SHIFT: begin
          if (sel_s2_r || !spi_on) begin
            state_r <= SIC_ST_IDLE;
          end
        end
        default: begin
          state_r <= SIC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 4'h0;
      rx_sh_r <= SIC_DATA_RST;
    end else if (state_r != SIC_ST_SHIFT || sel_s2_r) begin
      cnt_r   <= 4'h0;
    end else if (sck_rise) begin
      rx_sh_r <= {rx_sh_r[14:0], mosi_s2_r};
      cnt_r   <= frame_done ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // Transmit shifter loads data or the transmit checksum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_r    <= SIC_DATA_RST;
      tx_word_r  <= SIC_DATA_RST;
      ck_frame_r <= 1'b0;
    end else if (load_go) begin
      tx_sh_r    <= ck_next_r ? tx_ck_r : tx_buf_r;
      tx_word_r  <= tx_buf_r;
      ck_frame_r <= ck_next_r;
    end else if (state_r == SIC_ST_SHIFT && sck_fall && cnt_r != 4'h0) begin
      // The fall after a frame's last bit keeps the freshly loaded MSB
      tx_sh_r    <= {tx_sh_r[14:0], 1'b0};
    end
  end

  assign spi_miso_o  = frm16_r ? tx_sh_r[15] : tx_sh_r[7];
  assign spi_miso_oe = (state_r == SIC_ST_SHIFT) & ~sel_s2_r;

  // Busy while a frame is selected
  assign busy = (state_r == SIC_ST_SHIFT) & ~sel_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      SIC_CTRL_OFS: begin
        rd_mux[SIC_CTRL_SPI_EN]  = spi_en_r;
        rd_mux[SIC_CTRL_FRM16]   = frm16_r;
        rd_mux[SIC_CTRL_CK_EN]   = ck_en_r;
        rd_mux[SIC_CTRL_CK_NEXT] = ck_next_r;
      end
      SIC_STAT_OFS: begin
        rd_mux[SIC_STAT_RXNE]  = rxne_r;
        rd_mux[SIC_STAT_TXE]   = txe_r;
        rd_mux[SIC_STAT_CKERR] = ckerr_r;
        rd_mux[SIC_STAT_BUSY]  = busy;
      end
      SIC_DATA_OFS: begin
        rd_mux[15:0] = rx_buf_r;
      end
      SIC_POLY_OFS: begin
        rd_mux[15:0] = poly_r;
      end
      SIC_RXCK_OFS: begin
        rd_mux[15:0] = rx_ck_r;
      end
      SIC_TXCK_OFS: begin
        rd_mux[15:0] = tx_ck_r;
      end
      SIC_ACFG_OFS: begin
        rd_mux[SIC_ACFG_CHW]       = chw_r;
        rd_mux[SIC_ACFG_SW +: 2]   = sw_r;
        rd_mux[SIC_ACFG_IDLE_CLOCK_LEVEL]      = idle_clock_level_r;
        rd_mux[SIC_ACFG_STD +: 2]  = std_r;
        rd_mux[SIC_ACFG_PFS]       = pfs_r;
        rd_mux[SIC_ACFG_ROLE +: 2] = role_r;
        rd_mux[SIC_ACFG_AEN]       = aen_r;
        rd_mux[SIC_ACFG_PSEL]      = psel_bit_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule : sic_top

// ### include/sic_pkg.sv
// Shared constants and types for the SPI/I2S data, checksum and audio config block
package sic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] SIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SIC_STAT_OFS = 8'h08;
  localparam logic [7:0] SIC_DATA_OFS = 8'h0c;
  localparam logic [7:0] SIC_POLY_OFS = 8'h10;
  localparam logic [7:0] SIC_RXCK_OFS = 8'h14;
  localparam logic [7:0] SIC_TXCK_OFS = 8'h18;
  localparam logic [7:0] SIC_ACFG_OFS = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int SIC_CTRL_SPI_EN  = 0;
  localparam int SIC_CTRL_FRM16   = 1;
  localparam int SIC_CTRL_CK_EN   = 2;
  localparam int SIC_CTRL_CK_NEXT = 3;

  // Status register fields
  localparam int SIC_STAT_RXNE  = 0;
  localparam int SIC_STAT_TXE   = 1;
  localparam int SIC_STAT_CKERR = 4;
  localparam int SIC_STAT_BUSY  = 7;

  // Audio configuration fields
  localparam int SIC_ACFG_CHW  = 0;
  localparam int SIC_ACFG_SW   = 1;
  localparam int SIC_ACFG_IDLE_CLOCK_LEVEL = 3;
  localparam int SIC_ACFG_STD  = 4;
  localparam int SIC_ACFG_PFS  = 7;
  localparam int SIC_ACFG_ROLE = 8;
  localparam int SIC_ACFG_AEN  = 10;
  localparam int SIC_ACFG_PSEL = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0]  SIC_CTRL_RST = 4'h0;
  localparam logic [15:0] SIC_DATA_RST = 16'h0000;
  localparam logic [15:0] SIC_POLY_RST = 16'h0007;
  localparam logic [15:0] SIC_CK_RST   = 16'h0000;

  // Frame lengths in bits, minus one
  localparam logic [3:0] SIC_LAST8  = 4'h7;
  localparam logic [3:0] SIC_LAST16 = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    SIC_SW16  = 2'b00,
    SIC_SW24  = 2'b01,
    SIC_SW32  = 2'b10,
    SIC_SWBAD = 2'b11
  } sic_width_t;

  typedef enum logic [1:0] {
    SIC_STD_I2S   = 2'b00,
    SIC_STD_LEFT  = 2'b01,
    SIC_STD_RIGHT = 2'b10,
    SIC_STD_PCM   = 2'b11
  } sic_std_t;

  typedef enum logic [1:0] {
    SIC_ROLE_STX = 2'b00,
    SIC_ROLE_SRX = 2'b01,
    SIC_ROLE_MTX = 2'b10,
    SIC_ROLE_MRX = 2'b11
  } sic_role_t;

  typedef enum logic [1:0] {
    SIC_ST_IDLE  = 2'b01,
    SIC_ST_SHIFT = 2'b10
  } sic_state_t;

endpackage : sic_pkg

// ### include/sic_crc_if.sv
// Request and result of one frame-wide checksum step
`timescale 1ns/100ps
interface sic_crc_if;
  logic [15:0] poly;
  logic [15:0] cur;
  logic [15:0] data;
  logic        wide;
  logic [15:0] nxt;

  modport user   (output poly, output cur, output data, output wide, input nxt);
  modport engine (input poly, input cur, input data, input wide, output nxt);
endinterface : sic_crc_if

// ### rtl/sic_crc.sv
// Checksum over one whole 8-bit or 16-bit frame, MSB first
`timescale 1ns/100ps
module sic_crc
  import sic_pkg::*;
(
  sic_crc_if.engine ck
);

  function automatic logic [15:0] sic_step(
    input logic [15:0] poly,
    input logic [15:0] cur,
    input logic [15:0] data,
    input logic        wide
  );
    logic [15:0] c;
    logic        fb;
    c  = cur;
    fb = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (wide || i < 8) begin
        fb = (wide ? c[15] : c[7]) ^ data[(wide ? 15 : 7) - i];
        c  = {c[14:0], 1'b0};
        if (fb) begin
          c = c ^ poly;
        end
      end
    end
    if (!wide) begin
      c[15:8] = 8'h00;
    end
    return c;
  endfunction : sic_step

  // Narrow frames use the low byte of the polynomial only
  assign ck.nxt = sic_step(ck.poly, ck.cur, ck.data, ck.wide);

endmodule : sic_crc

// ### bench/sic_top_sva.sv
// Port assertions for the data, checksum and audio config block
`timescale 1ns/100ps
module sic_top_sva
  import sic_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        audio_active,
  input wire logic        audio_chan32,
  input wire logic [1:0]  audio_sample_width,
  input wire logic        idle_clock_level,
  input wire logic [1:0]  audio_standard_select,
  input wire logic        pcm_sync_length_select,
  input wire logic [1:0]  audio_role_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  logic wr_cfg;
  logic mapped;
  assign wr_cfg = psel && penable && pwrite && paddr == SIC_ACFG_OFS;
  assign mapped = paddr inside {SIC_CTRL_OFS, SIC_STAT_OFS, SIC_DATA_OFS, SIC_POLY_OFS,
                                SIC_RXCK_OFS, SIC_TXCK_OFS, SIC_ACFG_OFS};
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  chk_pcm_sync_gate: assert property (
    audio_standard_select != SIC_STD_PCM |-> !pcm_sync_length_select)
    else $error("sync length shown outside pcm");
  chk_chan_widen: assert property (
    audio_sample_width != SIC_SW16 |-> audio_chan32) else $error("channel not widened");
  chk_width_legal: assert property (
    audio_sample_width != SIC_SWBAD) else $error("forbidden sample width");
  chk_cfg_locked: assert property (
    audio_active && $past(audio_active) |-> $stable({audio_chan32, audio_sample_width,
      idle_clock_level, audio_standard_select, pcm_sync_length_select, audio_role_select}))
    else $error("audio settings changed while enabled");
  chk_cfg_write: assert property (
    wr_cfg && !audio_active ##1 audio_active |-> idle_clock_level == $past(pwdata[3])
      && audio_standard_select == $past(pwdata[5:4]) && audio_role_select == $past(pwdata[9:8]))
    else $error("enabled config differs from write");
  chk_aen_off: assert property (
    wr_cfg && !pwdata[SIC_ACFG_AEN] |=> !audio_active) else $error("audio stays active");
  chk_reserved_zero: assert property (
    psel && !penable && !pwrite && paddr == SIC_ACFG_OFS |=> prdata[15:12] == 4'h0
      && !prdata[6] && prdata[31:16] == 16'h0000) else $error("reserved config bits set");
endmodule : sic_top_sva

// ### bench/sic_peer.sv
// Serial bus master model that clocks frames through the block
`timescale 1ns/100ps
module sic_peer (
  input  wire logic clk,
  output logic      sck,
  output logic      sel_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end
  // Idle-low clock of eight clk periods, MSB first, reply taken at the rising edge
  task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
    begin
      rx = 16'h0000;
      @(posedge clk);
      sel_n <= 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
        mosi <= tx[i];
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        rx[i] = miso_oe ? miso : 1'bx;
        repeat (4) @(posedge clk);
        sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      sel_n <= 1'b1;
      mosi  <= ~mosi;
    end
  endtask : xfer
endmodule : sic_peer

// ### bench/sic_top_bench.sv
// Self-checking bench for the data, checksum and audio config block
`timescale 1ns/100ps
module sic_top_bench
  import sic_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        sck, sel_n, mosi, miso, miso_oe, act, ch32, icl, pfs;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  sw, std, role;
  logic [15:0] got, tx, mo, rc, tc, poly, cfg, d;
  int          fail_count, samples_checked, cyc, k, f, w;

  sic_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sck(sck), .spi_sel_n(sel_n), .spi_mosi(mosi), .spi_miso_o(miso),
    .spi_miso_oe(miso_oe), .audio_active(act), .audio_chan32(ch32), .audio_sample_width(sw),
    .idle_clock_level(icl), .audio_standard_select(std), .pcm_sync_length_select(pfs),
    .audio_role_select(role));
  sic_peer u_peer (.clk(pclk), .sck(sck), .sel_n(sel_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] v,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, rd, err);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, rd, err);
    chk(nm, e, rd);
  endtask : rdc

  function automatic logic [15:0] ck_step(logic [15:0] c, logic [15:0] p, logic [15:0] v,
                                          int wide);
    logic fb;
    for (int i = (wide ? 15 : 7); i >= 0; i--) begin
      fb = c[wide ? 15 : 7] ^ v[i];
      c = c << 1;
      if (!wide) c[15:8] = 8'h00;
      if (fb) c = c ^ (wide ? p : {8'h00, p[7:0]});
    end
    return c;
  endfunction : ck_step
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fail_count, samples_checked, cyc} = '0;
    k = $urandom(32'hbaad);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(SIC_DATA_OFS, 32'h0, "data reset");
    rdc(SIC_POLY_OFS, 32'h7, "poly reset");
    rdc(SIC_RXCK_OFS, 32'h0, "rx checksum reset");
    rdc(SIC_TXCK_OFS, 32'h0, "tx checksum reset");
    rdc(SIC_ACFG_OFS, 32'h0, "config reset");
    apb(1'b0, 8'h04, 32'h0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    wr(SIC_RXCK_OFS, 32'hffff);
    rdc(SIC_RXCK_OFS, 32'h0, "rx checksum read only");
    poly = $urandom;
    wr(SIC_POLY_OFS, {16'hffff, poly});
    rdc(SIC_POLY_OFS, {16'h0, poly}, "poly");
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      d[11:8] = {2'b10, k[1:0]};
      d[5:4] = k[1:0];
      d[2:1] = k[1:0];
      wr(SIC_ACFG_OFS, {16'h0, d});
      cfg = {4'h0, d[11:7], 1'b0, d[5:0]};
      if (k == 3) cfg[2:1] = 2'b10;
      rdc(SIC_ACFG_OFS, {16'h0, cfg}, "config");
      chk("outputs", {cfg[0] | (cfg[2:1] != 2'b00), cfg[2:1], cfg[3], cfg[5:4],
          cfg[7] & (k == 3), cfg[9:8]}, {act, ch32, sw, icl, std, pfs, role});
    end
    wr(SIC_ACFG_OFS, {16'h0, cfg | 16'h0400});
    wr(SIC_ACFG_OFS, 32'h0c00);
    rdc(SIC_ACFG_OFS, {16'h0, cfg | 16'h0400}, "locked config");
    chk("active", 32'h1, act);
    wr(SIC_ACFG_OFS, 32'h0);
    rdc(SIC_ACFG_OFS, {16'h0, cfg}, "kept protocol");
    wr(SIC_ACFG_OFS, 32'h0);
    wr(SIC_CTRL_OFS, 32'h1);
    wr(SIC_ACFG_OFS, 32'h0800);
    rdc(SIC_ACFG_OFS, 32'h0, "protocol while enabled");
    chk("spi mode outputs", 32'h0, {act, ch32, sw, icl, std, pfs, role});
    for (w = 0; w < 2; w++) begin
      wr(SIC_CTRL_OFS, 32'h0);
      wr(SIC_CTRL_OFS, 32'h1 | (w << 1));
      wr(SIC_CTRL_OFS, 32'h5 | (w << 1));
      rc = 16'h0;
      tc = 16'h0;
      for (f = 0; f < 6; f++) begin
        tx = $urandom;
        mo = (f == 0) ? 16'hffff : $urandom;
        mo = mo & (w ? 16'hffff : 16'h00ff);
        wr(SIC_DATA_OFS, {16'h0, tx});
        fork
          u_peer.xfer(mo, 8 + 8 * w, got);
          begin
            repeat (20) @(posedge pclk);
            apb(1'b0, SIC_STAT_OFS, 32'h0, rd, err);
          end
        join
        chk("busy in frame", 32'h1, rd[SIC_STAT_BUSY]);
        if (w == 0) tx[15:8] = 8'h00;
        chk("sent word", tx, got);
        rdc(SIC_DATA_OFS, mo, "received word");
        rc = ck_step(rc, poly, mo, w);
        tc = ck_step(tc, poly, tx, w);
      end
      apb(1'b0, SIC_STAT_OFS, 32'h0, rd, err);
      chk("idle status", 32'h0, rd & 32'h90);
      rdc(SIC_RXCK_OFS, rc, "rx checksum");
      rdc(SIC_TXCK_OFS, tc, "tx checksum");
      wr(SIC_CTRL_OFS, 32'hd | (w << 1));
      wr(SIC_DATA_OFS, $urandom);
      u_peer.xfer(rc ^ 16'h0001, 8 + 8 * w, got);
      chk("sent checksum", tc, got);
      apb(1'b0, SIC_STAT_OFS, 32'h0, rd, err);
      chk("checksum error", 32'h1, rd[SIC_STAT_CKERR]);
      wr(SIC_STAT_OFS, 32'h0);
      wr(SIC_CTRL_OFS, 32'h1 | (w << 1));
      wr(SIC_CTRL_OFS, 32'h5 | (w << 1));
      rdc(SIC_RXCK_OFS, 32'h0, "rx checksum cleared");
      rdc(SIC_TXCK_OFS, 32'h0, "tx checksum cleared");
    end
    results();
  end
endmodule : sic_top_bench

bind sic_top sic_top_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .audio_active(audio_active), .audio_chan32(audio_chan32),
  .audio_sample_width(audio_sample_width), .idle_clock_level(idle_clock_level),
  .audio_standard_select(audio_standard_select),
  .pcm_sync_length_select(pcm_sync_length_select), .audio_role_select(audio_role_select));
